/* File: design/rbt_transceiver.sv */
// registered bus transceiver top with axi4-lite control
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "rbt_consts.svh"

module rbt_transceiver (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [`RBT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`RBT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic [`RBT_DW-1:0]     a_bus_i,
  output logic      [`RBT_DW-1:0]     a_bus_o,
  output logic                        a_bus_oe,
  input  wire logic [`RBT_DW-1:0]     b_bus_i,
  output logic      [`RBT_DW-1:0]     b_bus_o,
  output logic                        b_bus_oe,
  input  wire logic                   a_capture_clock,
  input  wire logic                   b_capture_clock
);

  // ==========================================================
  // declarations
  rbt_pkg::rbt_top_state_t q;
  rbt_pkg::rbt_top_state_t n;

  logic [`RBT_SYNC_W-1:0] pin_sync;
  logic [`RBT_DW-1:0]     a_sync;
  logic [`RBT_DW-1:0]     b_sync;
  logic [1:0]             cap_sync;
  logic [1:0]             cap_edge;
  logic                   b_port_drive_enable;
  logic                   a_port_drive_enable_n;
  logic                   b_port_source_select;
  logic                   a_port_source_select;

  rbt_lane_if a_lane ();
  rbt_lane_if b_lane ();

  function automatic logic is_mapped(input logic [`RBT_ADDR_W-1:0] a);
    is_mapped = (a == `RBT_OFF_CTRL) || (a == `RBT_OFF_STORE) ||
                (a == `RBT_OFF_BUS);
  endfunction

  // ==========================================================
  // pin synchronisers
  // pins and capture clocks share one delay so data lines up with edges
  rbt_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({b_capture_clock, a_capture_clock, b_bus_i, a_bus_i}),
    .q     (pin_sync)
  );

  // synced levels double as the bus hold only in the both-live loop; a released bus is not held
  assign a_sync   = pin_sync[7:0];                      // [RL15]
  assign b_sync   = pin_sync[15:8];                     // [RL15]
  assign cap_sync = pin_sync[17:16];
  assign cap_edge = cap_sync & ~q.cap_prev;             // [RL2]

  assign b_port_drive_enable   = q.ctrl[`RBT_CTRL_BEN];
  assign a_port_drive_enable_n = q.ctrl[`RBT_CTRL_AEN_N];
  assign b_port_source_select  = q.ctrl[`RBT_CTRL_BSEL];
  assign a_port_source_select  = q.ctrl[`RBT_CTRL_ASEL];

  // ==========================================================
  // storage lanes
  // a lane: stores bus a, drives bus b
  assign a_lane.cap_edge = cap_edge[0];                 // [RL3]
  assign a_lane.own_bus  = a_sync;
  // b side driven from a: b readback carries a data into b store
  assign a_lane.live_bus = a_sync;                      // [RL12]
  assign a_lane.sel      = b_port_source_select;        // [RL7]
  assign a_lane.drv_en   = b_port_drive_enable;         // [RL6] [RL10]

  // b lane: stores bus b, drives bus a
  assign b_lane.cap_edge = cap_edge[1];                 // [RL3]
  assign b_lane.own_bus  = b_sync;
  assign b_lane.live_bus = b_sync;                      // [RL13]
  assign b_lane.sel      = a_port_source_select;        // [RL7]
  assign b_lane.drv_en   = ~a_port_drive_enable_n;      // [RL6] [RL9]

  rbt_lane u_a_lane (
    .clk   (clk),
    .rst_n (rst_n),
    .lp    (a_lane.lane)
  );

  rbt_lane u_b_lane (
    .clk   (clk),
    .rst_n (rst_n),
    .lp    (b_lane.lane)
  );

  // both lanes live and on: each output carries the other bus's input, closing a loop
  assign b_bus_o  = a_lane.out_data;                    // [RL5] [RL11]
  assign b_bus_oe = a_lane.out_en;                      // [RL8]
  assign a_bus_o  = b_lane.out_data;                    // [RL5] [RL11]
  assign a_bus_oe = b_lane.out_en;                      // [RL8]

  // ==========================================================
  // axi4-lite slave
  always_comb begin
    n          = q;
    n.cap_prev = cap_sync;

    if (s_axi_awvalid && q.awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata[7:0];
      n.wbe   = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got && !n.bvalid) begin
      n.bvalid = 1'b1;
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bresp  = is_mapped(n.aw_addr) ? `RBT_RESP_OKAY : `RBT_RESP_SLVERR;
      // only the control word is writable; other words ignore writes
      if (n.aw_addr == `RBT_OFF_CTRL && n.wbe) begin
        n.ctrl = n.wdata[3:0];
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;

    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = is_mapped(s_axi_araddr) ? `RBT_RESP_OKAY
                                         : `RBT_RESP_SLVERR;
      unique case (s_axi_araddr)
        `RBT_OFF_CTRL:  n.rdata = {28'h0000000, q.ctrl};
        `RBT_OFF_STORE: n.rdata = {16'h0000, b_lane.stored, a_lane.stored};
        `RBT_OFF_BUS:   n.rdata = {14'h0000, b_bus_oe, a_bus_oe,
                                   b_sync, a_sync};
        default:        n.rdata = 32'h00000000;
      endcase
    end
    n.arready = !n.rvalid;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.ctrl <= `RBT_CTRL_RST;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_b_oe_follow: assert property (                      // [RL6]
    b_bus_oe == $past(b_port_drive_enable))
    else $error("b drive enable does not follow control");

  a_a_oe_follow: assert property (                      // [RL6]
    a_bus_oe == !$past(a_port_drive_enable_n))
    else $error("a drive enable does not follow control");

  a_isolation_both: assert property (                   // [RL8]
    (!b_port_drive_enable && a_port_drive_enable_n)
      |=> (!a_bus_oe && !b_bus_oe))
    else $error("a port drives during isolation");

  a_store_a_edge: assert property (                     // [RL2] [RL3]
    cap_edge[0] |=> a_lane.stored == $past(a_sync))
    else $error("a store missed capture edge");

  a_store_b_hold: assert property (                     // [RL2]
    !cap_edge[1] |=> $stable(b_lane.stored))
    else $error("b store changed without capture edge");

  a_b_port_mux: assert property (                       // [RL1] [RL10]
    (b_port_drive_enable && !b_port_source_select)
      |=> (b_bus_oe && b_bus_o == $past(a_sync)))
    else $error("live a data not on bus b");

  a_a_port_stored: assert property (                    // [RL9] [RL11]
    (!a_port_drive_enable_n && a_port_source_select)
      |=> (a_bus_oe && a_bus_o == $past(b_lane.stored)))
    else $error("stored b data not on bus a");

  a_reinforce_both: assert property (                   // [RL5]
    (b_port_drive_enable && !a_port_drive_enable_n &&
     !a_port_source_select && !b_port_source_select)
      |=> (a_bus_o == $past(b_sync) && b_bus_o == $past(a_sync)))
    else $error("ports do not reinforce their inputs");

  a_mux_no_glitch: assert property (                    // [RL4]
    b_port_source_select ##1
    (b_port_source_select && $stable(a_lane.stored))
      |=> $stable(b_bus_o))
    else $error("bus b moved while stored data steady");

  a_write_resp: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |=> s_axi_bvalid)
    else $error("write response late");

  // bus handshake: one transfer in flight each way
  a_read_resp: assert property (
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read response late");

  a_resp_clear: assert property (
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write response not cleared");

  a_rresp_clear: assert property (
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read response not cleared");

  a_read_busy: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("new read accepted during response");

  a_write_busy: assert property (
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("new write accepted during response");

  a_store_b_edge: assert property (                     // [RL2] [RL3]
    cap_edge[1] |=> b_lane.stored == $past(b_sync))
    else $error("b store missed capture edge");

  a_store_a_hold: assert property (                     // [RL2]
    !cap_edge[0] |=> $stable(a_lane.stored))
    else $error("a store changed without capture edge");

  a_a_port_live: assert property (                      // [RL1] [RL9]
    (!a_port_drive_enable_n && !a_port_source_select)
      |=> (a_bus_oe && a_bus_o == $past(b_sync)))
    else $error("live b data not on bus a");

  a_b_port_stored: assert property (                    // [RL10] [RL11]
    (b_port_drive_enable && b_port_source_select)
      |=> (b_bus_oe && b_bus_o == $past(a_lane.stored)))
    else $error("stored a data not on bus b");

  a_mux_a_glitch: assert property (                     // [RL4]
    a_port_source_select ##1
    (a_port_source_select && $stable(b_lane.stored))
      |=> $stable(a_bus_o))
    else $error("bus a moved while stored data steady");

  a_b_drive_mode: assert property (                     // [RL10]
    (b_port_drive_enable && a_port_drive_enable_n)
      |=> (b_bus_oe && !a_bus_oe))
    else $error("wrong drivers with both enables high");

  a_a_drive_mode: assert property (                     // [RL9]
    (!b_port_drive_enable && !a_port_drive_enable_n)
      |=> (a_bus_oe && !b_bus_oe))
    else $error("wrong drivers with both enables low");

  c_store_both_from_a: cover property (                 // [RL12]
    b_port_drive_enable && !b_port_source_select ##1
    cap_edge[0] && cap_edge[1]);

  c_cross_stored: cover property (                      // [RL11]
    b_bus_oe && a_bus_oe && b_port_source_select && a_port_source_select);

  c_sel_switch: cover property (
    b_bus_oe ##1 $changed(b_port_source_select));

  c_store_both_from_b: cover property (                 // [RL13]
    !a_port_drive_enable_n && !a_port_source_select ##1
    cap_edge[0] && cap_edge[1]);

  c_reinforce_loop: cover property (                    // [RL5]
    b_bus_oe && a_bus_oe && !b_port_source_select && !a_port_source_select);

endmodule

/* File: design/rbt_consts.svh */
// constants for the registered bus transceiver
// How it works
// RL1: select low sends live opposite-bus data, select high sends stored data
// RL2: A capture rising edge loads A bus; B capture rising edge loads B bus
// RL3: capture loads happen whatever the selects and enables are
// RL4: switching between live and stored data gives no glitch on the bus
// RL5: both live and both driving: each port reinforces its input, bus holds
// RL6: B drivers on when B enable high; A drivers on when A enable low
// RL7: B select steers bus B output; A select steers bus A output
// RL8: B enable low, A enable high: both ports inputs, captures still work
// RL9: both enables low: port A drives live B or stored B, B is input
// RL10: both enables high: port B drives live A or stored A, A is input
// RL11: B on, A on, both selects high: stored data cross both ways at once
// RL12: port B driving from A lets A data load both registers
// RL13: port A driving from B lets B data load both registers
// RL14: host may pulse captures together on live; must stagger them on stored
// RL15: eight-bit ports and registers; bus hold keeps last resolved bus value (code holds a bus only in the RL5 loop)
`ifndef RBT_CONSTS_SVH
`define RBT_CONSTS_SVH

`define RBT_DW         8
`define RBT_SYNC_W     18
`define RBT_ADDR_W     4

// register offsets (byte addresses)
`define RBT_OFF_CTRL   4'h0
`define RBT_OFF_STORE  4'h4
`define RBT_OFF_BUS    4'h8

// control register fields
`define RBT_CTRL_BEN   0
`define RBT_CTRL_AEN_N 1
`define RBT_CTRL_BSEL  2
`define RBT_CTRL_ASEL  3
`define RBT_CTRL_RST   4'h2

// bus register fields
`define RBT_BUS_AOE    16
`define RBT_BUS_BOE    17

// axi responses
`define RBT_RESP_OKAY   2'h0
`define RBT_RESP_SLVERR 2'h2

`endif

/* File: design/rbt_pkg.sv */
// types for the registered bus transceiver
`include "rbt_consts.svh"

package rbt_pkg;

  typedef struct packed {
    logic [`RBT_SYNC_W-1:0] s1;
    logic [`RBT_SYNC_W-1:0] s2;
  } rbt_sync_state_t;

  typedef struct packed {
    logic [`RBT_DW-1:0] stored;
    logic [`RBT_DW-1:0] out_data;
    logic               out_en;
  } rbt_lane_state_t;

  typedef struct packed {
    logic [1:0]             cap_prev;
    logic [3:0]             ctrl;
    logic                   awready;
    logic                   wready;
    logic                   aw_got;
    logic                   w_got;
    logic [`RBT_ADDR_W-1:0] aw_addr;
    logic [7:0]             wdata;
    logic                   wbe;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
  } rbt_top_state_t;

endpackage

/* File: design/rbt_lane_if.sv */
// one transfer direction between the top and its storage lane
`timescale 1ns/1ns
`include "rbt_consts.svh"

interface rbt_lane_if;
  logic               cap_edge;
  logic [`RBT_DW-1:0] own_bus;
  logic [`RBT_DW-1:0] live_bus;
  logic               sel;
  logic               drv_en;
  logic [`RBT_DW-1:0] stored;
  logic [`RBT_DW-1:0] out_data;
  logic               out_en;

  modport lane (input cap_edge, own_bus, live_bus, sel, drv_en,
                output stored, out_data, out_en);
  modport ctl (output cap_edge, own_bus, live_bus, sel, drv_en,
               input stored, out_data, out_en);
endinterface

/* File: design/rbt_sync.sv */
// two-flop synchroniser for bus pins and capture pins
`timescale 1ns/1ns
`include "rbt_consts.svh"

module rbt_sync (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [`RBT_SYNC_W-1:0] d,
  output logic      [`RBT_SYNC_W-1:0] q
);
  rbt_pkg::rbt_sync_state_t st_q;
  rbt_pkg::rbt_sync_state_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    // first stage feeds nothing but the second
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

/* File: design/rbt_lane.sv */
// storage register and output mux for one direction
`timescale 1ns/1ns
`include "rbt_consts.svh"

module rbt_lane (
  input  wire logic   clk,
  input  wire logic   rst_n,
  rbt_lane_if.lane    lp
);
  rbt_pkg::rbt_lane_state_t st_q;
  rbt_pkg::rbt_lane_state_t st_d;

  always_comb begin
    st_d = st_q;
    // capture ignores select and enable
    if (lp.cap_edge) begin
      st_d.stored = lp.own_bus;                         // [RL2] [RL3]
    end
    // registered mux: the pin sees one clean change per switch
    st_d.out_data = lp.sel ? st_q.stored : lp.live_bus; // [RL1] [RL4]
    st_d.out_en   = lp.drv_en;                          // [RL6]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lp.stored   = st_q.stored;
  assign lp.out_data = st_q.out_data;
  assign lp.out_en   = st_q.out_en;
endmodule

/* File: tb/rbt_bus_partner.sv */
// far side of both buses: drives a bus wherever the device is off and its drive enable is set
`timescale 1ns/1ns
`include "rbt_consts.svh"

module rbt_bus_partner (
  input  wire logic               clk,
  input  wire logic [`RBT_DW-1:0] a_bus_o,
  input  wire logic               a_bus_oe,
  input  wire logic [`RBT_DW-1:0] b_bus_o,
  input  wire logic               b_bus_oe,
  input  wire logic               a_drv_en,
  input  wire logic [`RBT_DW-1:0] a_drv_val,
  input  wire logic               b_drv_en,
  input  wire logic [`RBT_DW-1:0] b_drv_val,
  output logic      [`RBT_DW-1:0] a_bus,
  output logic      [`RBT_DW-1:0] b_bus
);
  // ======================================
  // wire resolution
  logic [`RBT_DW-1:0] a_last_q;
  logic [`RBT_DW-1:0] b_last_q;

  // a released wire flips every cycle so a stale value never looks held
  always_ff @(posedge clk) begin
    a_last_q <= a_bus;
    b_last_q <= b_bus;
  end

  assign a_bus = a_bus_oe ? a_bus_o
               : (a_drv_en ? a_drv_val : ~a_last_q);
  assign b_bus = b_bus_oe ? b_bus_o
               : (b_drv_en ? b_drv_val : ~b_last_q);
endmodule

/* File: tb/tb_registered_bus_transceiver.sv */
// self-checking bench for the registered bus transceiver
`timescale 1ns/1ns
`include "rbt_consts.svh"

module tb_registered_bus_transceiver;
  // ======================================
  // signals
  logic                   clk = 0, rst_n = 0, awready, wready, arready;
  logic                   awvalid = 0, wvalid = 0, bready = 0;
  logic                   arvalid = 0, rready = 0, bvalid, rvalid;
  logic                   a_oe, b_oe, a_cap = 0, b_cap = 0, f;
  logic                   a_en = 1, b_en = 1;
  logic [`RBT_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]            wdata = '0, rdata, rd;
  logic [3:0]             wstrb = '0, c;
  logic [1:0]             bresp, rresp, rs;
  logic [`RBT_DW-1:0]     a_o, b_o, a_bus, b_bus, a_val = '0, b_val = '0;
  logic [7:0]             x = '0, y = '0, sa = '0, sb = '0;
  logic [15:0]            e;
  int                     miscompares, comparisons;

  rbt_transceiver u_rbt_transceiver (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .a_bus_i(a_bus),
    .a_bus_o(a_o), .a_bus_oe(a_oe), .b_bus_i(b_bus), .b_bus_o(b_o),
    .b_bus_oe(b_oe), .a_capture_clock(a_cap), .b_capture_clock(b_cap));

  rbt_bus_partner u_rbt_bus_partner (
    .clk(clk), .a_bus_o(a_o), .a_bus_oe(a_oe), .b_bus_o(b_o),
    .b_bus_oe(b_oe), .a_drv_en(a_en), .a_drv_val(a_val), .b_drv_en(b_en),
    .b_drv_val(b_val), .a_bus(a_bus), .b_bus(b_bus));

  // ======================================
  // helpers
  task automatic test_done();
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ev,
                     input logic [31:0] gv);
    comparisons++;
    if (gv !== ev) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ev, gv);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    bit pa, pw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1;
    pw = 1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awready === 1'b1) begin
        pa = 0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1) begin
        pw = 0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // settled levels of both wires; two passes resolve one-way chains
  function automatic logic [15:0] buses(input logic [3:0] m);
    logic [7:0] ea, eb;
    ea = x;
    eb = y;
    repeat (2) begin
      ea = !m[1] ? (m[3] ? sb : eb) : x;
      eb = m[0] ? (m[2] ? sa : ea) : y;
    end
    return {eb, ea};
  endfunction

  // capture pulses stay wide: narrow ones may be missed by the synchroniser
  task automatic cap(input bit ca, input bit cb);
    @(posedge clk);
    a_cap <= ca;
    b_cap <= cb;
    repeat (4) @(posedge clk);
    a_cap <= 1'b0;
    b_cap <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  task automatic cap_side(input bit side);
    e = buses(c);
    if (side) sb = e[15:8];
    else sa = e[7:0];
    cap(!side, side);
  endtask

  task automatic check_mode();
    e = buses(c);
    chk("a_bus_oe", {31'h0, !c[1]}, {31'h0, a_oe});
    chk("b_bus_oe", {31'h0, c[0]}, {31'h0, b_oe});
    chk("bus a", {24'h0, e[7:0]}, {24'h0, a_bus});
    chk("bus b", {24'h0, e[15:8]}, {24'h0, b_bus});
    rd_reg(`RBT_OFF_STORE);
    chk("store", {16'h0, sb, sa}, rd);
    chk("store resp", {30'h0, `RBT_RESP_OKAY}, {30'h0, rs});
    rd_reg(`RBT_OFF_BUS);
    chk("bus reg", {14'h0, c[0], !c[1], e}, rd);
    rd_reg(`RBT_OFF_CTRL);
    chk("ctrl", {28'h0, c}, rd);
  endtask

  // ======================================
  // clock, watchdog, tests
  initial forever #10 clk = ~clk;

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial begin
    void'($urandom(99692));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(`RBT_OFF_CTRL);
    chk("ctrl reset", 32'h2, rd);
    rd_reg(4'hc);
    chk("unmapped resp", {30'h0, `RBT_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
    wr(`RBT_OFF_CTRL, 32'hd, 4'h0);
    chk("ctrl wr resp", {30'h0, `RBT_RESP_OKAY}, {30'h0, rs});
    wr(`RBT_OFF_STORE, 32'hffff, 4'hf);
    chk("store wr resp", {30'h0, `RBT_RESP_OKAY}, {30'h0, rs});
    wr(4'hc, 32'hf, 4'hf);
    chk("unmapped wr resp", {30'h0, `RBT_RESP_SLVERR}, {30'h0, rs});
    c = 4'h2;
    check_mode();
    for (int i = 0; i < 16; i++) begin
      if (i == 1) continue;
      c = 4'(i);
      x = 8'($urandom);
      y = 8'($urandom);
      a_val <= x;
      b_val <= y;
      wr(`RBT_OFF_CTRL, 32'(i), 4'hf);
      repeat (12) @(posedge clk);
      check_mode();
      if (c[3:2] == 2'b00) begin
        e = buses(c);
        sa = e[7:0];
        sb = e[15:8];
        cap(1'b1, 1'b1);
      end else begin
        f = 1'($urandom);
        cap_side(f);
        cap_side(!f);
      end
      check_mode();
    end
    // both live and both driving: the loop must keep the last value
    wr(`RBT_OFF_CTRL, 32'h0, 4'hf);
    repeat (12) @(posedge clk);
    wr(`RBT_OFF_CTRL, 32'h1, 4'hf);
    repeat (12) @(posedge clk);
    a_en <= 1'b0;
    b_en <= 1'b0;
    repeat (12) @(posedge clk);
    chk("held a", {24'h0, y}, {24'h0, a_bus});
    chk("held b", {24'h0, y}, {24'h0, b_bus});
    test_done();
  end
endmodule
